// >>> gdr_fault_latch.sv
module gdr_fault_latch
   import gdr_pkg::*;
#(
   parameter int WIDTH = DATA_W
) (
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   input  wire logic [WIDTH-1:0] set_in,
   input  wire logic [WIDTH-1:0] clear_in,
   output logic      [WIDTH-1:0] flags_out
);

   logic [WIDTH-1:0] flags_reg;
   logic [WIDTH-1:0] flags_next;

   // A condition present in the clearing cycle keeps its flag
   always_comb begin
      flags_next = set_in | (flags_reg & ~clear_in);
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         flags_reg <= '0;
      end else begin
         flags_reg <= flags_next;
      end
   end

   assign flags_out = flags_reg;

endmodule

// >>> gdr_gate_mux.sv
module gdr_gate_mux
   import gdr_pkg::*;
(
   input  wire logic             [5:0] pwm_in,
   input  wire gdr_pwm_mode_type       mode_in,
   input  wire logic                   freewheel_in,
   input  wire logic                   direction_in,
   input  wire logic                   brake_in,
   input  wire logic                   coast_in,
   output logic                  [2:0] gate_hi_out,
   output logic                  [2:0] gate_lo_out,
   output logic                        gate_hiz_out
);

   // Six-step table: hall code to driven high phase and sunk low phase
   function automatic logic [5:0] commutate(input logic [2:0] hall);
      logic [5:0] sel;
      case (hall)
         3'h1:    sel = 6'h22;
         3'h2:    sel = 6'h11;
         3'h3:    sel = 6'h21;
         3'h4:    sel = 6'h0c;
         3'h5:    sel = 6'h0a;
         3'h6:    sel = 6'h14;
         default: sel = 6'h00;
      endcase
      return sel;
   endfunction

   logic [5:0] sel;
   logic [2:0] hi_sel;
   logic [2:0] lo_sel;
   logic [2:0] in_hi;
   logic [2:0] in_lo;

   always_comb begin
      in_hi        = {pwm_in[5], pwm_in[3], pwm_in[1]};
      in_lo        = {pwm_in[4], pwm_in[2], pwm_in[0]};
      sel          = commutate({pwm_in[4], pwm_in[3], pwm_in[2]});
      hi_sel       = direction_in ? sel[2:0] : sel[5:3];
      lo_sel       = direction_in ? sel[5:3] : sel[2:0];
      gate_hi_out  = 3'h0;
      gate_lo_out  = 3'h0;
      gate_hiz_out = 1'b0;
      case (mode_in)
         MODE_SIX: begin
            // Both inputs of a leg high turns the leg off to avoid shoot-through
            gate_hi_out = in_hi & ~in_lo;
            gate_lo_out = in_lo & ~in_hi;
         end
         MODE_THREE: begin
            gate_hi_out = in_lo & in_hi;
            gate_lo_out = in_lo & ~in_hi;
         end
         MODE_SINGLE: begin
            if (brake_in) begin
               gate_lo_out = 3'h7;
            end else if (pwm_in[5]) begin
               gate_hi_out = hi_sel;
               gate_lo_out = lo_sel;
            end else begin
               gate_lo_out = freewheel_in ? lo_sel : (lo_sel | hi_sel);
            end
         end
         MODE_INDEP: begin
            gate_hi_out = in_hi;
            gate_lo_out = in_lo;
         end
         default: begin
            gate_hi_out = 3'h0;
         end
      endcase
      if (coast_in) begin
         gate_hi_out  = 3'h0;
         gate_lo_out  = 3'h0;
         gate_hiz_out = 1'b1;
      end
   end

endmodule

// >>> gdr_host_model.sv
module gdr_host_model
   import gdr_pkg::*;
(
   input  wire logic          clk_in,
   input  wire logic   [10:0] read_data_in,
   input  wire logic          read_valid_in,
   output gdr_frame_type      frame_out
);
   timeunit 1ns;
   timeprecision 1ps;

   initial frame_out = '0;

   // Released word lines show the inverse, so a stale value can never pass
   task automatic send(input logic wr, input logic [3:0] addr, input logic [10:0] data);
      @(posedge clk_in);
      frame_out <= '{valid: 1'b1, write: wr, addr: addr, data: data};
      @(posedge clk_in);
      frame_out <= '{valid: 1'b0, write: ~wr, addr: ~addr, data: ~data};
   endtask

   // The host writes whatever address it is given, including read-only and unmapped ones
   task automatic write_reg(input logic [3:0] addr, input logic [10:0] data);
      send(1'b1, addr, data);
   endtask

   task automatic read_reg(input logic [3:0] addr, output logic [10:0] data, output logic ok);
      ok = 1'b0;
      data = '0;
      send(1'b0, addr, 11'h000);
      #1;
      for (int k = 0; k < 4 && !ok; k++) begin
         if (read_valid_in === 1'b1) begin
            ok = 1'b1;
            data = read_data_in;
         end else begin
            @(posedge clk_in);
            #1;
         end
      end
   endtask
endmodule

// >>> gdr_pkg.sv
package gdr_pkg;

   localparam int DATA_W = 11;
   localparam int ADDR_W = 4;

   localparam logic [3:0] ADDR_STATUS2  = 4'h1;
   localparam logic [3:0] ADDR_DRV_CTRL = 4'h2;
   localparam logic [3:0] ADDR_HS       = 4'h3;
   localparam logic [3:0] ADDR_LS       = 4'h4;

   localparam logic [10:0] DRV_CTRL_RESET   = 11'h000;
   localparam logic [10:0] HS_RESET         = 11'h3ff;
   localparam logic [10:0] LS_RESET         = 11'h7ff;
   localparam logic [10:0] STATUS_RESET     = 11'h000;
   localparam logic [10:0] LOCKED_CTRL_MASK = 11'h007;
   localparam logic [2:0]  LOCK_ON          = 3'h6;
   localparam logic [2:0]  LOCK_OFF         = 3'h3;
   localparam logic [1:0]  OVERCURRENT_RESPONSE_MODE_RETRY   = 2'h1;
   localparam int          OTW_BIT          = 7;

   localparam int CLK_PERIOD_NS      = 4;
   localparam int PEAK_HOLD_BASE_NS  = 500;
   localparam int HOLD_W             = 10;

   typedef enum logic [1:0] {
      MODE_SIX    = 2'h0,
      MODE_THREE  = 2'h1,
      MODE_SINGLE = 2'h2,
      MODE_INDEP  = 2'h3
   } gdr_pwm_mode_type;

   typedef struct packed {
      logic             reserved;
      logic             pump_uv_fault_disable;
      logic             gate_fault_disable;
      logic             overtemp_warning_report;
      gdr_pwm_mode_type pwm_mode;
      logic             single_input_freewheel_select;
      logic             single_input_direction_bit;
      logic             coast;
      logic             brake;
      logic             clear_latched_faults;
   } gdr_drv_ctrl_type;

   typedef struct packed {
      logic [2:0] lock;
      logic [3:0] high_side_source_current;
      logic [3:0] high_side_sink_current;
   } gdr_hs_type;

   typedef struct packed {
      logic       per_cycle_fault_clear;
      logic [1:0] peak_current_hold_time;
      logic [3:0] low_side_source_current;
      logic [3:0] low_side_sink_current;
   } gdr_ls_type;

   typedef struct packed {
      logic phase_a_sense_overcurrent;
      logic phase_b_sense_overcurrent;
      logic phase_c_sense_overcurrent;
      logic overtemp_warning;
      logic pump_undervoltage;
      logic gate_fault_a_high;
      logic gate_fault_a_low;
      logic gate_fault_b_high;
      logic gate_fault_b_low;
      logic gate_fault_c_high;
      logic gate_fault_c_low;
   } gdr_status_type;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [3:0]  addr;
      logic [10:0] data;
   } gdr_frame_type;

   typedef struct packed {
      gdr_drv_ctrl_type ctrl;
      gdr_hs_type       hs;
      gdr_ls_type       ls;
      logic [10:0]      rd_data;
      logic             rd_valid;
      logic [2:0]       gate_hi;
      logic [2:0]       gate_lo;
      logic             gate_hiz;
      logic [9:0]       peak_cnt;
      logic             peak_active;
      logic             fault_sum;
      logic             fault_n;
      logic [5:0]       pwm_prev;
   } gdr_state_type;

endpackage

// >>> gdr_regs.sv
module gdr_regs
   import gdr_pkg::*;
(
   input  wire logic           clk_in,
   input  wire logic           rst_in,
   input  wire gdr_frame_type  frame_in,
   input  wire gdr_status_type fault_cond_in,
   input  wire logic     [5:0] pwm_in,
   input  wire logic     [1:0] overcurrent_response_mode_in,
   output logic         [10:0] read_data_out,
   output logic                read_valid_out,
   output logic          [2:0] gate_high_out,
   output logic          [2:0] gate_low_out,
   output logic                gate_hiz_out,
   output logic                peak_drive_out,
   output logic                fault_summary_out,
   output logic                fault_pin_active_low_out,
   output logic          [3:0] high_side_source_current_out,
   output logic          [3:0] high_side_sink_current_out,
   output logic          [3:0] low_side_source_current_out,
   output logic          [3:0] low_side_sink_current_out
);

   localparam gdr_state_type ST_RESET = '{
      ctrl:        DRV_CTRL_RESET,
      hs:          HS_RESET,
      ls:          LS_RESET,
      rd_data:     11'h000,
      rd_valid:    1'b0,
      gate_hi:     3'h0,
      gate_lo:     3'h0,
      gate_hiz:    1'b0,
      peak_cnt:    10'h000,
      peak_active: 1'b0,
      fault_sum:   1'b0,
      fault_n:     1'b1,
      pwm_prev:    6'h00
   };

   function automatic logic [HOLD_W-1:0] hold_cycles(input logic [1:0] code);
      int ns;
      ns = PEAK_HOLD_BASE_NS << code;
      return HOLD_W'(ns / CLK_PERIOD_NS);
   endfunction

   gdr_state_type  st_reg;
   gdr_state_type  st_next;
   gdr_status_type flags;
   gdr_status_type fault_set;
   logic [10:0]    fault_clear;
   logic [10:0]    report_mask;
   logic [2:0]     mux_hi;
   logic [2:0]     mux_lo;
   logic           mux_hiz;
   logic           locked;
   logic           wr_hit;
   logic           pwm_edge;
   logic           retry_clear;

   always_comb begin
      fault_set                  = fault_cond_in;
      fault_set.pump_undervoltage = fault_cond_in.pump_undervoltage
                                    & ~st_reg.ctrl.pump_uv_fault_disable;
      if (st_reg.ctrl.gate_fault_disable) begin
         fault_set.gate_fault_a_high = 1'b0;
         fault_set.gate_fault_a_low  = 1'b0;
         fault_set.gate_fault_b_high = 1'b0;
         fault_set.gate_fault_b_low  = 1'b0;
         fault_set.gate_fault_c_high = 1'b0;
         fault_set.gate_fault_c_low  = 1'b0;
      end
      // Any change on the PWM inputs counts as a new PWM input
      pwm_edge    = pwm_in != st_reg.pwm_prev;
      retry_clear = st_reg.ls.per_cycle_fault_clear
                    & (overcurrent_response_mode_in == OVERCURRENT_RESPONSE_MODE_RETRY) & pwm_edge;
      fault_clear = {11{st_reg.ctrl.clear_latched_faults}};
      fault_clear[10:8] = fault_clear[10:8] | {3{retry_clear}};
   end

   gdr_fault_latch #(
      .WIDTH (DATA_W)
   ) u_status (
      .clk_in    (clk_in),
      .rst_in    (rst_in),
      .set_in    (fault_set),
      .clear_in  (fault_clear),
      .flags_out (flags)
   );

   gdr_gate_mux u_mux (
      .pwm_in       (pwm_in),
      .mode_in      (st_reg.ctrl.pwm_mode),
      .freewheel_in (st_reg.ctrl.single_input_freewheel_select),
      .direction_in (st_reg.ctrl.single_input_direction_bit | pwm_in[1]),
      .brake_in     (st_reg.ctrl.brake | pwm_in[0]),
      .coast_in     (st_reg.ctrl.coast),
      .gate_hi_out  (mux_hi),
      .gate_lo_out  (mux_lo),
      .gate_hiz_out (mux_hiz)
   );

   always_comb begin
      st_next  = st_reg;
      locked   = st_reg.hs.lock == LOCK_ON;
      wr_hit   = frame_in.valid & frame_in.write;
      st_next.ctrl.clear_latched_faults = 1'b0;
      st_next.pwm_prev = pwm_in;

      if (wr_hit) begin
         case (frame_in.addr)
            ADDR_DRV_CTRL: begin
               if (locked) begin
                  // Coast, brake and clear stay writable so a locked part can still stop
                  st_next.ctrl = (st_reg.ctrl & ~LOCKED_CTRL_MASK)
                                 | (frame_in.data & LOCKED_CTRL_MASK);
               end else begin
                  st_next.ctrl = frame_in.data;
               end
            end
            ADDR_HS: begin
               if (locked) begin
                  if (frame_in.data[10:8] == LOCK_OFF) begin
                     st_next.hs.lock = LOCK_OFF;
                  end
               end else begin
                  st_next.hs.high_side_source_current = frame_in.data[7:4];
                  st_next.hs.high_side_sink_current   = frame_in.data[3:0];
                  if (frame_in.data[10:8] == LOCK_ON) begin
                     st_next.hs.lock = LOCK_ON;
                  end
               end
            end
            ADDR_LS: begin
               if (!locked) begin
                  st_next.ls = frame_in.data;
               end
            end
            default: begin
               // Status register and unmapped addresses take no write
               st_next.rd_valid = 1'b0;
            end
         endcase
      end

      st_next.rd_valid = frame_in.valid & ~frame_in.write;
      case (frame_in.addr)
         ADDR_STATUS2:  st_next.rd_data = flags;
         ADDR_DRV_CTRL: st_next.rd_data = st_reg.ctrl;
         ADDR_HS:       st_next.rd_data = st_reg.hs;
         ADDR_LS:       st_next.rd_data = st_reg.ls;
         default:       st_next.rd_data = 11'h000;
      endcase
      if (!st_next.rd_valid) begin
         st_next.rd_data = st_reg.rd_data;
      end

      st_next.gate_hi  = mux_hi;
      st_next.gate_lo  = mux_lo;
      st_next.gate_hiz = mux_hiz;

      // Every gate transition restarts the peak current window
      if ((mux_hi != st_reg.gate_hi) || (mux_lo != st_reg.gate_lo)) begin
         st_next.peak_cnt    = hold_cycles(st_reg.ls.peak_current_hold_time) - 10'h001;
         st_next.peak_active = 1'b1;
      end else if (st_reg.peak_cnt != 10'h000) begin
         st_next.peak_cnt    = st_reg.peak_cnt - 10'h001;
         st_next.peak_active = 1'b1;
      end else begin
         st_next.peak_active = 1'b0;
      end

      report_mask          = 11'h7ff;
      report_mask[OTW_BIT] = st_reg.ctrl.overtemp_warning_report;
      st_next.fault_sum    = |(flags & report_mask);
      st_next.fault_n      = ~(|(flags & report_mask));
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         st_reg <= ST_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   assign read_data_out                = st_reg.rd_data;
   assign read_valid_out               = st_reg.rd_valid;
   assign gate_high_out                = st_reg.gate_hi;
   assign gate_low_out                 = st_reg.gate_lo;
   assign gate_hiz_out                 = st_reg.gate_hiz;
   assign peak_drive_out               = st_reg.peak_active;
   assign fault_summary_out            = st_reg.fault_sum;
   assign fault_pin_active_low_out     = st_reg.fault_n;
   assign high_side_source_current_out = st_reg.hs.high_side_source_current;
   assign high_side_sink_current_out   = st_reg.hs.high_side_sink_current;
   assign low_side_source_current_out  = st_reg.ls.low_side_source_current;
   assign low_side_sink_current_out    = st_reg.ls.low_side_sink_current;

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);

   sequence s_status_read;
      frame_in.valid && !frame_in.write && frame_in.addr == ADDR_STATUS2;
   endsequence

   sequence s_ls_write_locked;
      frame_in.valid && frame_in.write && frame_in.addr == ADDR_LS
         && st_reg.hs.lock == LOCK_ON;
   endsequence

   chk_status_readback: assert property (
      s_status_read |=> read_valid_out && read_data_out == $past(flags))
      else $error("status read returned wrong data");

   chk_clear_self_reset: assert property (
      st_reg.ctrl.clear_latched_faults |=> !st_reg.ctrl.clear_latched_faults)
      else $error("clear bit did not return to zero");

   chk_clear_empties: assert property (
      (st_reg.ctrl.clear_latched_faults && fault_cond_in == '0) |=> flags == '0)
      else $error("latched faults survived clear");

   chk_lock_blocks_ls: assert property (
      s_ls_write_locked |=> $stable(st_reg.ls))
      else $error("low-side register changed while locked");

   chk_lock_values: assert property (
      st_reg.hs.lock == LOCK_ON || st_reg.hs.lock == LOCK_OFF)
      else $error("lock field holds an illegal code");

   chk_coast_off: assert property (
      st_reg.ctrl.coast |=> gate_high_out == 3'h0 && gate_low_out == 3'h0 && gate_hiz_out)
      else $error("gate on during coast");

   chk_pump_uv_mask: assert property (
      (st_reg.ctrl.pump_uv_fault_disable && !flags.pump_undervoltage)
         |=> !flags.pump_undervoltage)
      else $error("pump undervoltage latched while disabled");

   chk_gate_fault_mask: assert property (
      (st_reg.ctrl.gate_fault_disable && flags[5:0] == 6'h00) |=> flags[5:0] == 6'h00)
      else $error("gate fault latched while disabled");

   chk_otw_unreported: assert property (
      (flags == 11'h080 && !st_reg.ctrl.overtemp_warning_report)
         |=> !fault_summary_out && fault_pin_active_low_out)
      else $error("overtemperature warning reported while masked");

   chk_fault_pin_mirror: assert property (
      (flags[6:0] != 7'h00 || flags[10:8] != 3'h0) |=> fault_summary_out ##0 !fault_pin_active_low_out)
      else $error("fault pin does not follow latched fault");

   chk_brake_lows: assert property (
      (st_reg.ctrl.pwm_mode == MODE_SINGLE && st_reg.ctrl.brake && !st_reg.ctrl.coast)
         |=> gate_low_out == 3'h7 && gate_high_out == 3'h0)
      else $error("brake did not turn on all low sides");

endmodule

// >>> tb_gdr_regs.sv
module tb_gdr_regs
   import gdr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic           clk_in = 1'b0;
   logic           rst_in = 1'b1;
   gdr_frame_type  frame;
   gdr_status_type fault_cond = '0;
   logic [5:0]     pwm = 6'h00;
   logic [1:0]     ocmode = 2'h0;
   logic [10:0]    rd_data;
   logic           rd_valid;
   logic [2:0]     g_hi;
   logic [2:0]     g_lo;
   logic           g_hiz;
   logic           peak;
   logic           f_sum;
   logic           f_pin_n;
   logic [3:0]     hs_src;
   logic [3:0]     hs_snk;
   logic [3:0]     ls_src;
   logic [3:0]     ls_snk;
   int             bad_count = 0;
   int             samples_checked = 0;
   int             n;

   always #2 clk_in = ~clk_in;

   gdr_host_model host (.clk_in(clk_in), .read_data_in(rd_data), .read_valid_in(rd_valid),
                        .frame_out(frame));

   gdr_regs dut (.clk_in(clk_in), .rst_in(rst_in), .frame_in(frame), .fault_cond_in(fault_cond),
                 .pwm_in(pwm), .overcurrent_response_mode_in(ocmode), .read_data_out(rd_data),
                 .read_valid_out(rd_valid), .gate_high_out(g_hi), .gate_low_out(g_lo),
                 .gate_hiz_out(g_hiz), .peak_drive_out(peak), .fault_summary_out(f_sum),
                 .fault_pin_active_low_out(f_pin_n), .high_side_source_current_out(hs_src),
                 .high_side_sink_current_out(hs_snk), .low_side_source_current_out(ls_src),
                 .low_side_sink_current_out(ls_snk));

   task automatic tally_and_finish();
      $display("checked %0d bad %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic check(input string name, input logic [10:0] seen, input logic [10:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic settle();
      repeat (3) @(posedge clk_in);
      #1;
   endtask

   task automatic wr(input logic [3:0] a, input logic [10:0] d);
      host.write_reg(a, d);
      settle();
   endtask

   task automatic expect_reg(input string name, input logic [3:0] a, input logic [10:0] e);
      logic [10:0] d;
      logic        ok;
      host.read_reg(a, d, ok);
      if (!ok) begin
         bad_count++;
         $display("BAD %s read answer missing", name);
         tally_and_finish();
      end else begin
         check(name, d, e);
      end
   endtask

   task automatic pulse_fault(input logic [10:0] bits);
      @(posedge clk_in);
      fault_cond <= gdr_status_type'(bits);
      settle();
      @(posedge clk_in);
      fault_cond <= '0;
      settle();
   endtask

   task automatic gate_case(input logic [10:0] c, input logic [5:0] p, input logic [2:0] hi,
                            input logic [2:0] lo);
      wr(ADDR_DRV_CTRL, c);
      @(posedge clk_in);
      pwm <= p;
      settle();
      check("gate_high", g_hi, hi);
      check("gate_low", g_lo, lo);
      check("gate_hiz", g_hiz, c[2]);
   endtask

   initial begin
      repeat (5) @(posedge clk_in);
      rst_in <= 1'b0;
      @(posedge clk_in);
      expect_reg("status2_rst", ADDR_STATUS2, 11'h000);
      expect_reg("ctrl_rst", ADDR_DRV_CTRL, 11'h000);
      expect_reg("hs_rst", ADDR_HS, 11'h3ff);
      expect_reg("ls_rst", ADDR_LS, 11'h7ff);
      expect_reg("unmapped", 4'h5, 11'h000);
      check("hs_codes_rst", {3'h0, hs_src, hs_snk}, 11'h0ff);
      check("ls_codes_rst", {3'h0, ls_src, ls_snk}, 11'h0ff);
      check("fault_pin_rst", f_pin_n, 1'b1);
      wr(ADDR_STATUS2, 11'h7ff);
      expect_reg("status2_ro", ADDR_STATUS2, 11'h000);
      // Each flag alone, so a swapped bit position shows up
      for (int i = 0; i < 11; i++) begin
         pulse_fault(11'h001 << i);
         check("summary", f_sum, i != OTW_BIT);
         check("fault_pin", f_pin_n, i == OTW_BIT);
         expect_reg("status2", ADDR_STATUS2, 11'h001 << i);
         wr(ADDR_DRV_CTRL, 11'h001);
         expect_reg("status2_clr", ADDR_STATUS2, 11'h000);
      end
      expect_reg("clear_self", ADDR_DRV_CTRL, 11'h000);
      wr(ADDR_DRV_CTRL, 11'h080);
      pulse_fault(11'h080);
      check("otw_summary", f_sum, 1'b1);
      check("otw_pin", f_pin_n, 1'b0);
      wr(ADDR_DRV_CTRL, 11'h301);
      pulse_fault(11'h07f);
      expect_reg("masked", ADDR_STATUS2, 11'h000);
      pulse_fault(11'h07f);
      expect_reg("mask_off_ctrl", ADDR_DRV_CTRL, 11'h300);
      wr(ADDR_DRV_CTRL, 11'h000);
      pulse_fault(11'h060);
      expect_reg("unmasked", ADDR_STATUS2, 11'h060);
      wr(ADDR_DRV_CTRL, 11'h001);
      gate_case(11'h000, 6'h21, 3'h4, 3'h1);
      gate_case(11'h020, 6'h10, 3'h0, 3'h4);
      gate_case(11'h060, 6'h21, 3'h4, 3'h1);
      gate_case(11'h040, 6'h24, 3'h4, 3'h2);
      gate_case(11'h048, 6'h24, 3'h2, 3'h4);
      gate_case(11'h040, 6'h26, 3'h2, 3'h4);
      gate_case(11'h040, 6'h04, 3'h0, 3'h6);
      gate_case(11'h050, 6'h04, 3'h0, 3'h2);
      gate_case(11'h042, 6'h24, 3'h0, 3'h7);
      gate_case(11'h040, 6'h25, 3'h0, 3'h7);
      gate_case(11'h044, 6'h24, 3'h0, 3'h0);
      gate_case(11'h000, 6'h00, 3'h0, 3'h0);
      // Window length is counted in samples one cycle apart
      for (int code = 0; code < 4; code++) begin
         wr(ADDR_LS, {1'b0, 2'(code), 8'hff});
         for (int k = 0; k < 1100 && peak !== 1'b0; k++) begin
            @(posedge clk_in);
            #1;
         end
         check("peak_idle", peak, 1'b0);
         @(posedge clk_in);
         pwm <= pwm ^ 6'h20;
         #1;
         for (int k = 0; k < 8 && peak !== 1'b1; k++) begin
            @(posedge clk_in);
            #1;
         end
         n = 0;
         for (int k = 0; k < 1100 && peak === 1'b1; k++) begin
            n++;
            @(posedge clk_in);
            #1;
         end
         check("peak_len", 11'(n), 11'(125 << code));
      end
      wr(ADDR_LS, 11'h7ff);
      @(posedge clk_in);
      ocmode <= OVERCURRENT_RESPONSE_MODE_RETRY;
      pulse_fault(11'h400);
      expect_reg("retry_held", ADDR_STATUS2, 11'h400);
      @(posedge clk_in);
      pwm <= pwm ^ 6'h20;
      settle();
      expect_reg("retry_clr", ADDR_STATUS2, 11'h000);
      wr(ADDR_LS, 11'h3ff);
      pulse_fault(11'h200);
      @(posedge clk_in);
      pwm <= pwm ^ 6'h20;
      settle();
      expect_reg("no_retry", ADDR_STATUS2, 11'h200);
      @(posedge clk_in);
      ocmode <= 2'h0;
      wr(ADDR_DRV_CTRL, 11'h001);
      wr(ADDR_HS, 11'h6aa);
      expect_reg("lock_on", ADDR_HS, 11'h6aa);
      check("hs_codes", {hs_src, hs_snk}, 11'h0aa);
      wr(ADDR_LS, 11'h000);
      expect_reg("ls_locked", ADDR_LS, 11'h3ff);
      wr(ADDR_DRV_CTRL, 11'h0ff);
      expect_reg("ctrl_locked", ADDR_DRV_CTRL, 11'h006);
      check("coast_locked", g_hiz, 1'b1);
      wr(ADDR_HS, 11'h555);
      expect_reg("lock_other", ADDR_HS, 11'h6aa);
      wr(ADDR_HS, 11'h3ff);
      expect_reg("unlock", ADDR_HS, 11'h3aa);
      wr(ADDR_HS, 11'h155);
      expect_reg("unlocked_other", ADDR_HS, 11'h355);
      wr(ADDR_LS, 11'h2a5);
      expect_reg("ls_open", ADDR_LS, 11'h2a5);
      check("ls_codes", {ls_src, ls_snk}, 11'h0a5);
      tally_and_finish();
   end
endmodule
